// ### include/cbrw_pkg.sv
// constants and types for the contactless block read/write command handler
package cbrw_pkg;
  localparam int BYTE_W = 8;
  typedef logic [BYTE_W-1:0] cbrw_byte_t;
  // ----------------------------------------------------------------------
  // command and response codes
  // ----------------------------------------------------------------------
  localparam cbrw_byte_t CMD_READ = 8'h06;
  localparam cbrw_byte_t CMD_WRITE = 8'h08;
  localparam cbrw_byte_t RSP_READ = 8'h07;
  localparam cbrw_byte_t RSP_WRITE = 8'h09;
  // ----------------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------------
  localparam cbrw_byte_t ST_OK = 8'h00;
  localparam cbrw_byte_t ST_ERR = 8'hFF;
  localparam cbrw_byte_t ERR_SVC = 8'hA1;
  localparam cbrw_byte_t ERR_BLK = 8'hA2;
  localparam cbrw_byte_t ERR_MIX = 8'hA3;
  // ----------------------------------------------------------------------
  // field limits and layout
  // ----------------------------------------------------------------------
  localparam cbrw_byte_t K_MIN = 8'h01;
  localparam cbrw_byte_t K_RD_MAX = 8'h0F;
  localparam cbrw_byte_t K_WR_MAX = 8'h0B;
  localparam cbrw_byte_t K_WR_SPLIT = 8'h08;
  localparam cbrw_byte_t M_MIN = 8'h01;
  localparam cbrw_byte_t M_RD_MAX = 8'h0F;
  localparam cbrw_byte_t M_WR_MAX_LO = 8'h0C;
  localparam cbrw_byte_t M_WR_MAX_HI = 8'h0B;
  localparam cbrw_byte_t ID_LAST = 8'h07;
  localparam cbrw_byte_t SVC_ID_BYTES = 8'h02;
  localparam int M_LIST = 16;
  localparam int BLK_SH = 4;
  localparam int EL2_BIT = 7;
  localparam logic [1:0] EP_HEAD = 2'h0;
  localparam logic [1:0] EP_NUM = 2'h1;
  localparam logic [1:0] EP_EXT = 2'h2;
  // ----------------------------------------------------------------------
  // reply byte positions
  // ----------------------------------------------------------------------
  localparam cbrw_byte_t IDX_ID_LAST = 8'h08;
  localparam cbrw_byte_t IDX_SF1 = 8'h09;
  localparam cbrw_byte_t IDX_SF2 = 8'h0A;
  localparam cbrw_byte_t IDX_CNT = 8'h0B;
  localparam cbrw_byte_t RSP_HDR_LEN = 8'h0B;
  localparam cbrw_byte_t RSP_DATA_OFF = 8'h0C;
  typedef enum logic [8:0] {
    ST_CMD  = 9'h001,
    ST_ID   = 9'h002,
    ST_K    = 9'h004,
    ST_SVC  = 9'h008,
    ST_M    = 9'h010,
    ST_LIST = 9'h020,
    ST_DATA = 9'h040,
    ST_SKIP = 9'h080,
    ST_RESP = 9'h100
  } cbrw_state_e;
endpackage

// ### hdl/cbrw_fifo.sv
// reply byte fifo with a registered head
`timescale 1ns/100ps
module cbrw_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  // depth must be a power of two: pointers wrap by overflow
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic push, load;

  assign in_ready_out = cnt_r != (AW+1)'(DEPTH);
  assign push = in_valid_in && in_ready_out;
  assign load = (cnt_r != '0) && (!out_valid_out || out_ready_in);

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wp_r] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (load) begin
        rp_r <= rp_r + 1'b1;
      end
      if (push && !load) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (load && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_valid_out <= 1'b0;
      out_data_out <= '0;
    end else if (load) begin
      out_valid_out <= 1'b1;
      out_data_out <= mem_r[rp_r];
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end
endmodule // cbrw_fifo

// ### hdl/cbrw_cmd.sv
// block read/write command handler of a contactless tag
`timescale 1ns/100ps
module cbrw_cmd #(
  parameter int NUM_BLOCKS = 32,
  parameter logic [63:0] TAG_ID = 64'h0123_4567_89AB_CDEF, // arbitrary
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire cbrw_pkg::cbrw_byte_t rx_data_in,
  input wire logic rx_valid_in,
  input wire logic rx_last_in,
  output logic rx_ready_out,
  output cbrw_pkg::cbrw_byte_t tx_data_out,
  output logic tx_valid_out,
  output logic tx_last_out,
  input wire logic tx_ready_in
);
  import cbrw_pkg::*;
  localparam int BW = $clog2(NUM_BLOCKS);

  cbrw_state_e state_r, state_nxt;
  cbrw_byte_t cnt_r, cnt_nxt, k_r, k_nxt, m_r, m_nxt, sf2_r, sf2_nxt;
  cbrw_byte_t dcnt_r, dcnt_nxt, txi_r, txi_nxt;
  cbrw_byte_t tx_byte, tx_len, m_lim, di;
  logic [1:0][BYTE_W-1:0] svc0_r, svc0_nxt;
  logic wr_r, wr_nxt, done_r, done_nxt, idok_r, idok_nxt;
  logic idbad_r, idbad_nxt, el3_r, el3_nxt;
  logic [1:0] ep_r, ep_nxt;
  logic [3:0] ent_r, ent_nxt;
  logic rx_ready_r, acc, push, f_ready, tx_last;
  cbrw_byte_t mem_r [NUM_BLOCKS << BLK_SH];
  logic [BW-1:0] blist_r [M_LIST];
  logic [BW+BLK_SH-1:0] wr_addr, rd_addr;

  function automatic cbrw_byte_t id_byte(input cbrw_byte_t i);
    id_byte = TAG_ID[int'(ID_LAST - i) * BYTE_W +: BYTE_W];
  endfunction

  assign acc = rx_valid_in && rx_ready_r;
  assign push = state_r == ST_RESP;
  assign rx_ready_out = rx_ready_r;

  // ----------------------------------------------------------------------
  // request parser
  // ----------------------------------------------------------------------
  always_comb begin
    m_lim = !wr_r ? M_RD_MAX :
            (k_r <= K_WR_SPLIT) ? M_WR_MAX_LO : M_WR_MAX_HI;
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    k_nxt = k_r;
    m_nxt = m_r;
    sf2_nxt = sf2_r;
    dcnt_nxt = dcnt_r;
    txi_nxt = txi_r;
    svc0_nxt = svc0_r;
    wr_nxt = wr_r;
    done_nxt = done_r;
    idok_nxt = idok_r;
    idbad_nxt = idbad_r;
    el3_nxt = el3_r;
    ep_nxt = ep_r;
    ent_nxt = ent_r;
    if (acc) begin
      unique case (state_r)
        ST_CMD: begin
          wr_nxt = rx_data_in == CMD_WRITE;
          cnt_nxt = '0;
          sf2_nxt = ST_OK;
          done_nxt = 1'b0;
          idok_nxt = 1'b0;
          idbad_nxt = 1'b0;
          state_nxt = (rx_data_in == CMD_READ || rx_data_in == CMD_WRITE) ?
                      ST_ID : ST_SKIP;
        end
        ST_ID: begin
          if (rx_data_in != id_byte(cnt_r)) begin
            idbad_nxt = 1'b1;
          end
          cnt_nxt = cnt_r + 8'h01;
          if (cnt_r == ID_LAST) begin
            cnt_nxt = '0;
            idok_nxt = !idbad_nxt;
            state_nxt = idbad_nxt ? ST_SKIP : ST_K;
          end
        end
        ST_K: begin
          k_nxt = rx_data_in;
          if (rx_data_in < K_MIN ||
              rx_data_in > (wr_r ? K_WR_MAX : K_RD_MAX)) begin
            sf2_nxt = ERR_SVC;
            state_nxt = ST_SKIP;
          end else begin
            state_nxt = ST_SVC;
          end
        end
        ST_SVC: begin
          // identifier value itself is ignored, only sameness matters
          if (cnt_r < SVC_ID_BYTES) begin
            svc0_nxt[cnt_r[0]] = rx_data_in;
          end else if (rx_data_in != svc0_r[cnt_r[0]]) begin
            sf2_nxt = ERR_MIX;
            state_nxt = ST_SKIP;
          end
          cnt_nxt = cnt_r + 8'h01;
          if (state_nxt == ST_SVC &&
              cnt_r == cbrw_byte_t'((k_r << 1) - 8'h01)) begin
            state_nxt = ST_M;
          end
        end
        ST_M: begin
          m_nxt = rx_data_in;
          ent_nxt = '0;
          ep_nxt = EP_HEAD;
          if (rx_data_in < M_MIN || rx_data_in > m_lim) begin
            sf2_nxt = ERR_BLK;
            state_nxt = ST_SKIP;
          end else begin
            state_nxt = ST_LIST;
          end
        end
        ST_LIST: begin
          // head byte bit set marks a two-byte entry
          if (ep_r == EP_HEAD) begin
            el3_nxt = !rx_data_in[EL2_BIT];
            ep_nxt = EP_NUM;
          end else if (ep_r == EP_NUM && el3_r) begin
            ep_nxt = EP_EXT;
          end else begin
            ep_nxt = EP_HEAD;
            ent_nxt = ent_r + 4'h1;
            if (ent_r == 4'(m_r - 8'h01)) begin
              dcnt_nxt = '0;
              done_nxt = !wr_r;
              state_nxt = wr_r ? ST_DATA : ST_SKIP;
            end
          end
        end
        ST_DATA: begin
          dcnt_nxt = dcnt_r + 8'h01;
          if (dcnt_r == cbrw_byte_t'((m_r << BLK_SH) - 8'h01)) begin
            done_nxt = 1'b1;
            state_nxt = ST_SKIP;
          end
        end
        ST_SKIP, ST_RESP: begin
        end
      endcase
      // the frame end decides: reply, or drop a broken/foreign request
      if (rx_last_in) begin
        state_nxt = (idok_nxt && (done_nxt || sf2_nxt != ST_OK)) ?
                    ST_RESP : ST_CMD;
      end
    end
    if (push && f_ready) begin
      txi_nxt = txi_r + 8'h01;
      if (tx_last) begin
        txi_nxt = '0;
        state_nxt = ST_CMD;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_CMD;
      cnt_r <= '0;
      k_r <= '0;
      m_r <= '0;
      sf2_r <= ST_OK;
      dcnt_r <= '0;
      txi_r <= '0;
      svc0_r <= '0;
      wr_r <= 1'b0;
      done_r <= 1'b0;
      idok_r <= 1'b0;
      idbad_r <= 1'b0;
      el3_r <= 1'b0;
      ep_r <= EP_HEAD;
      ent_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      k_r <= k_nxt;
      m_r <= m_nxt;
      sf2_r <= sf2_nxt;
      dcnt_r <= dcnt_nxt;
      txi_r <= txi_nxt;
      svc0_r <= svc0_nxt;
      wr_r <= wr_nxt;
      done_r <= done_nxt;
      idok_r <= idok_nxt;
      idbad_r <= idbad_nxt;
      el3_r <= el3_nxt;
      ep_r <= ep_nxt;
      ent_r <= ent_nxt;
    end
  end

  // input is held off until the last reply byte is pushed into the fifo, so requests never overlap reply building
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_ready_r <= 1'b0;
    end else begin
      rx_ready_r <= state_nxt != ST_RESP;
    end
  end

  // ----------------------------------------------------------------------
  // block list and block storage
  // ----------------------------------------------------------------------
  // block numbers wrap modulo the block count; no range error is raised
  assign wr_addr = {blist_r[dcnt_r[BYTE_W-1:BLK_SH]], dcnt_r[BLK_SH-1:0]};

  always_ff @(posedge clk_in) begin
    if (acc && state_r == ST_LIST && ep_r == EP_NUM) begin
      blist_r[ent_r] <= rx_data_in[BW-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (acc && state_r == ST_DATA) begin
      mem_r[wr_addr] <= rx_data_in;
    end
  end

  // ----------------------------------------------------------------------
  // reply builder
  // ----------------------------------------------------------------------
  always_comb begin
    di = txi_r - RSP_DATA_OFF;
    rd_addr = {blist_r[di[BYTE_W-1:BLK_SH]], di[BLK_SH-1:0]};
    tx_len = (!wr_r && sf2_r == ST_OK) ?
             cbrw_byte_t'(RSP_DATA_OFF + (m_r << BLK_SH)) :
             RSP_HDR_LEN;
    tx_last = txi_r == cbrw_byte_t'(tx_len - 8'h01);
    if (txi_r == '0) begin
      tx_byte = wr_r ? RSP_WRITE : RSP_READ;
    end else if (txi_r <= IDX_ID_LAST) begin
      tx_byte = id_byte(txi_r - 8'h01);
    end else if (txi_r == IDX_SF1) begin
      tx_byte = (sf2_r == ST_OK) ? ST_OK : ST_ERR;
    end else if (txi_r == IDX_SF2) begin
      tx_byte = sf2_r;
    end else if (txi_r == IDX_CNT) begin
      tx_byte = m_r;
    end else begin
      tx_byte = mem_r[rd_addr];
    end
  end

  cbrw_fifo #(
    .WIDTH(BYTE_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(push),
    .in_data_in({tx_last, tx_byte}),
    .in_ready_out(f_ready),
    .out_valid_out(tx_valid_out),
    .out_data_out({tx_last_out, tx_data_out}),
    .out_ready_in(tx_ready_in)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_byte(cbrw_state_e st);
    acc && state_r == st && !rx_last_in;
  endsequence
  sequence s_emit(cbrw_byte_t idx);
    push && f_ready && txi_r == idx;
  endsequence

  a_rd_svc_range: assert property (s_byte(ST_K) and
    (!wr_r && (rx_data_in == '0 || rx_data_in > K_RD_MAX))
    |=> sf2_r == ERR_SVC && state_r == ST_SKIP)
    else $error("read service count not rejected");
  a_wr_svc_range: assert property (s_byte(ST_K) and
    (wr_r && rx_data_in > K_WR_MAX) |=> sf2_r == ERR_SVC)
    else $error("write service count not rejected");
  a_svc_mismatch: assert property (s_byte(ST_SVC) and
    (cnt_r >= SVC_ID_BYTES && rx_data_in != svc0_r[cnt_r[0]])
    |=> sf2_r == ERR_MIX)
    else $error("differing service ids not rejected");
  a_rd_blk_range: assert property (s_byte(ST_M) and
    (!wr_r && rx_data_in > M_RD_MAX) |=> sf2_r == ERR_BLK)
    else $error("read block count not rejected");
  a_wr_blk_low: assert property (s_byte(ST_M) and
    (wr_r && k_r <= K_WR_SPLIT && rx_data_in == M_WR_MAX_LO)
    |=> state_r == ST_LIST)
    else $error("write of twelve blocks refused");
  a_wr_blk_high: assert property (s_byte(ST_M) and
    (wr_r && k_r > K_WR_SPLIT && rx_data_in > M_WR_MAX_HI)
    |=> sf2_r == ERR_BLK)
    else $error("write block count not rejected");
  a_reply_code: assert property (s_emit('0) |->
    tx_byte == (wr_r ? RSP_WRITE : RSP_READ) && !tx_last)
    else $error("wrong reply code");
  a_status_pair: assert property (s_emit(IDX_SF1) |->
    tx_byte == ((sf2_r == ST_OK) ? ST_OK : ST_ERR) ##1
    (push && txi_r == IDX_SF2 && tx_byte == sf2_r))
    else $error("status flags inconsistent");
  a_err_short: assert property (push && sf2_r != ST_OK |->
    tx_len == RSP_HDR_LEN)
    else $error("error reply carries block data");
  a_no_foreign: assert property (push |-> idok_r && !idbad_r)
    else $error("reply to foreign identifier");
  a_write_clean: assert property (acc && state_r == ST_DATA |->
    sf2_r == ST_OK && wr_r && idok_r)
    else $error("write data stored after an error");
endmodule // cbrw_cmd

// ### verification/cbrw_reader_model.sv
// reader/writer model: sends request frames and collects reply bytes
`timescale 1ns/100ps
module cbrw_reader_model (
  input wire logic clk_in,
  output cbrw_pkg::cbrw_byte_t req_data_out,
  output logic req_valid_out,
  output logic req_last_out,
  input wire logic req_ready_in,
  input wire cbrw_pkg::cbrw_byte_t rsp_data_in,
  input wire logic rsp_valid_in,
  input wire logic rsp_last_in,
  output logic rsp_ready_out
);
  import cbrw_pkg::*;
  logic [8:0] got_q[$];
  int frames = 0;
  bit stall = 1'b0;
  int tick = 0;
  initial begin
    req_data_out = 8'h00;
    req_valid_out = 1'b0;
    req_last_out = 1'b0;
  end
  // ----------------------------------------------------------------------
  // reply sink
  // ----------------------------------------------------------------------
  // stalls two cycles of three so the reply fifo really fills
  always @(negedge clk_in) begin
    tick <= tick + 1;
    rsp_ready_out <= !stall || (tick % 3 == 0);
  end
  always @(posedge clk_in) begin
    if (rsp_valid_in && rsp_ready_out) begin
      got_q.push_back({rsp_last_in, rsp_data_in});
      if (rsp_last_in) frames++;
    end
  end
  // ----------------------------------------------------------------------
  // request source
  // ----------------------------------------------------------------------
  function automatic cbrw_byte_t pat(input int blk, input int i,
      input int seed);
    return 8'((blk * 16 + i + seed * 55) ^ 90);
  endfunction
  task automatic put(input cbrw_byte_t b, input logic last);
    @(negedge clk_in);
    req_data_out = b;
    req_valid_out = 1'b1;
    req_last_out = last;
    do @(posedge clk_in); while (!req_ready_in);
  endtask
  task automatic send_req(input cbrw_byte_t cmd, input logic [63:0] id,
      input int k, input bit mix, input int m, input bit three,
      input int base, input int seed);
    cbrw_byte_t q[$];
    q.push_back(cmd);
    for (int i = 7; i >= 0; i--) q.push_back(id[i*8 +: 8]);
    q.push_back(8'(k));
    for (int i = 0; i < k; i++) begin
      q.push_back(8'h09);
      q.push_back((mix && i == k - 1) ? 8'h01 : 8'h00);
    end
    q.push_back(8'(m));
    for (int j = 0; j < m; j++) begin
      q.push_back(three ? 8'h00 : 8'h80);
      q.push_back(8'(base + j));
      if (three) q.push_back(8'h00);
    end
    if (cmd == CMD_WRITE) begin
      for (int j = 0; j < m; j++) begin
        for (int i = 0; i < 16; i++) begin
          q.push_back(pat(base + j, i, seed));
        end
      end
    end
    foreach (q[n]) put(q[n], n == q.size() - 1);
    // released data line must not keep showing the last byte
    @(negedge clk_in);
    req_valid_out = 1'b0;
    req_last_out = 1'b0;
    req_data_out = ~req_data_out;
  endtask
endmodule // cbrw_reader_model

// ### verification/testbench.sv
// self-checking testbench of the block read/write command handler
`timescale 1ns/100ps
module testbench;
  import cbrw_pkg::*;
  localparam logic [63:0] ID = 64'h0123_4567_89AB_CDEF; // arbitrary
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  cbrw_byte_t rx_data;
  logic rx_valid;
  logic rx_last;
  logic rx_ready;
  cbrw_byte_t tx_data;
  logic tx_valid;
  logic tx_last;
  logic tx_ready;
  int err_count = 0;
  int check_count = 0;
  logic [8:0] exp_q[$];
  cbrw_cmd #(.NUM_BLOCKS(32), .TAG_ID(ID), .FIFO_DEPTH(32)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .rx_data_in(rx_data),
    .rx_valid_in(rx_valid), .rx_last_in(rx_last), .rx_ready_out(rx_ready),
    .tx_data_out(tx_data), .tx_valid_out(tx_valid), .tx_last_out(tx_last),
    .tx_ready_in(tx_ready));
  cbrw_reader_model u_rdr (
    .clk_in(clk_in), .req_data_out(rx_data), .req_valid_out(rx_valid),
    .req_last_out(rx_last), .req_ready_in(rx_ready),
    .rsp_data_in(tx_data), .rsp_valid_in(tx_valid),
    .rsp_last_in(tx_last), .rsp_ready_out(tx_ready));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  // ----------------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------------
  task automatic check_rsp(input string what, input logic [8:0] exp,
      input logic [8:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_len(input string what, input int exp, input int got);
    check_count++;
    if (got != exp) begin
      err_count++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic exp_hdr(input cbrw_byte_t code, input cbrw_byte_t sf2,
      input bit more);
    exp_q.push_back({1'b0, code});
    for (int i = 7; i >= 0; i--) exp_q.push_back({1'b0, ID[i*8 +: 8]});
    exp_q.push_back({1'b0, (sf2 == ST_OK) ? ST_OK : ST_ERR});
    exp_q.push_back({!more, sf2});
  endtask
  task automatic exp_data(input int m, input int base, input int seed);
    exp_q.push_back({1'b0, 8'(m)});
    for (int j = 0; j < m; j++) begin
      for (int i = 0; i < 16; i++) begin
        exp_q.push_back({j == m - 1 && i == 15, u_rdr.pat(base + j, i, seed)});
      end
    end
  endtask
  // sends one request and compares the whole reply with exp_q
  task automatic run(input cbrw_byte_t cmd, input logic [63:0] id,
      input int k, input bit mix, input int m, input bit three,
      input int base, input int seed, input string what);
    int n;
    int lim;
    n = u_rdr.frames;
    lim = (exp_q.size() == 0) ? 60 : 3000;
    u_rdr.send_req(cmd, id, k, mix, m, three, base, seed);
    check_rsp({what, " ready"}, 9'(exp_q.size() == 0), 9'(rx_ready));
    for (int c = 0; c < lim && u_rdr.frames == n; c++) @(negedge clk_in);
    check_len({what, " length"}, exp_q.size(), u_rdr.got_q.size());
    foreach (exp_q[i]) begin
      if (i < u_rdr.got_q.size()) begin
        check_rsp(what, exp_q[i], u_rdr.got_q[i]);
      end
    end
    exp_q.delete();
    u_rdr.got_q.delete();
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_write_ok();
    exp_hdr(RSP_WRITE, ST_OK, 1'b0);
    run(CMD_WRITE, ID, 1, 0, 12, 0, 0, 0, "write k1 m12");
    exp_hdr(RSP_WRITE, ST_OK, 1'b0);
    run(CMD_WRITE, ID, 11, 0, 11, 1, 12, 0, "write k11 m11");
    $display("test write_ok done");
  endtask
  task automatic t_read_ok();
    u_rdr.stall = 1'b1;
    exp_hdr(RSP_READ, ST_OK, 1'b1);
    exp_data(15, 4, 0);
    run(CMD_READ, ID, 15, 0, 15, 1, 4, 0, "read stalled");
    u_rdr.stall = 1'b0;
    exp_hdr(RSP_READ, ST_OK, 1'b1);
    exp_data(1, 22, 0);
    run(CMD_READ, ID, 1, 0, 1, 0, 22, 0, "read k1 m1");
    $display("test read_ok done");
  endtask
  task automatic t_errors();
    int k_t[10] = '{0, 16, 1, 1, 2, 0, 12, 9, 8, 2};
    int m_t[10] = '{1, 1, 0, 16, 1, 1, 1, 12, 13, 1};
    cbrw_byte_t e_t[10] = '{ERR_SVC, ERR_SVC, ERR_BLK, ERR_BLK, ERR_MIX,
        ERR_SVC, ERR_SVC, ERR_BLK, ERR_BLK, ERR_MIX};
    for (int i = 0; i < 10; i++) begin
      exp_hdr(i < 5 ? RSP_READ : RSP_WRITE, e_t[i], 1'b0);
      run(i < 5 ? CMD_READ : CMD_WRITE, ID, k_t[i],
          i == 4 || i == 9, m_t[i], 0, 0, 1,
          "error reply");
    end
    // refused writes carried other data: blocks must be untouched
    exp_hdr(RSP_READ, ST_OK, 1'b1);
    exp_data(12, 0, 0);
    run(CMD_READ, ID, 8, 0, 12, 0, 0, 0, "read after refusals");
    $display("test errors done");
  endtask
  task automatic t_foreign();
    run(CMD_READ, ID ^ 64'h1, 1, 0, 1, 0, 0, 0, "foreign low");
    run(CMD_WRITE, ID ^ {1'b1, 63'h0}, 1, 0, 1, 0, 0, 1, "foreign hi");
    exp_hdr(RSP_READ, ST_OK, 1'b1);
    exp_data(1, 0, 0);
    run(CMD_READ, ID, 1, 0, 1, 0, 0, 0, "read after foreign");
    $display("test foreign done");
  endtask
  // ----------------------------------------------------------------------
  // sequence, watchdog and verdict
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    t_write_ok();
    t_read_ok();
    t_errors();
    t_foreign();
    report_and_stop();
  end
  // whole run needs well under 10000 cycles
  initial begin
    #300us;
    err_count++;
    $display("[FAIL] watchdog expected finish seen hang");
    report_and_stop();
  end
endmodule // testbench
